// >>> rtl/scsoc_clock_control.v
// system clock select and oscillator control with wishbone registers
//
// Implementation choice: register access over Wishbone.
`include "scsoc_defines.vh"
module scsoc_clock_control #(
    parameter REDUCED   = 0,                 // 1 selects reduced variant
    parameter RC_START  = `SCSOC_RC_START_CYC,  // rc start in rc pulses
    parameter XTL_START = `SCSOC_XTL_START_CYC, // crystal start pulses
    parameter STAB_LONG = `SCSOC_STAB_RESET     // power-on stabilization
) (
    input  wire        clk_i,                // bus and control clock
    input  wire        rst_i,                // synchronous reset, high
    input  wire        wb_cyc_i,             // wishbone cycle
    input  wire        wb_stb_i,             // wishbone strobe
    input  wire        wb_we_i,              // wishbone write enable
    input  wire [15:0] wb_adr_i,             // wishbone byte address
    input  wire [7:0]  wb_dat_i,             // wishbone write data
    input  wire        wb_sel_i,             // wishbone byte select
    output reg  [7:0]  wb_dat_o,             // wishbone read data
    output wire        wb_ack_o,             // wishbone acknowledge
    input  wire        rc_osc_i,             // raw 500 khz rc oscillator
    input  wire        slow_osc_i,           // raw crystal oscillator
    input  wire        ext_clock_input_pin_i, // external clock pin level
    input  wire        stop_i,               // stop mode request, level
    input  wire        wake_i,               // external interrupt wake
    output reg         fast_clock_o,         // divided fast clock
    output reg         fast_oscillator_clock_o, // gated oscillator clock
    output reg         slow_clock_o,         // gated slow clock
    output reg         doubled_slow_clock_o, // doubled slow clock
    output reg         system_clock_o,       // glitch-free system clock
    output reg         cpu_stall_o,          // cpu wait request
    output reg         ext_pin_gpio_o,       // pin as general input
    output reg         gpio_in_o,            // pin value as port input
    output reg         crystal_pin_in_oe_o,  // crystal in pin enable
    output reg         crystal_pin_out_o,    // crystal out pin drive
    output reg         crystal_pin_out_oe_o  // crystal out pin enable
);
    // raw oscillator and pin sync stages
    reg [1:0]  rc_sync;                      // rc clock synchroniser
    reg [1:0]  sl_sync;                      // crystal synchroniser
    reg [1:0]  ex_sync;                      // ext pin synchroniser
    reg [1:0]  wk_sync;                      // wake synchroniser
    reg [1:0]  st_sync;                      // stop synchroniser
    reg        rc_prev;                      // rc edge detect
    reg        sl_prev;                      // slow edge detect
    reg        ex_prev;                      // ext edge detect
    // control registers
    reg [7:0]  ctrl0;                        // divider and mode
    reg [7:0]  ctrl1;                        // select and enables
    reg        ack;                          // ack register
    // sequencing
    reg        stopped;                      // in stop mode
    reg        boot;                         // first start after reset
    reg [15:0] hs_start;                     // rc start counter
    reg [13:0] hs_stab;                      // rc stabilization counter
    reg        hs_ready;                     // fast oscillator supplied
    reg [15:0] ls_start;                     // crystal start counter
    reg [13:0] ls_stab;                      // slow stabilization counter
    reg        ls_ready;                     // slow clock supplied
    reg        hs_en_prev;                   // enable edge detect
    reg [2:0]  div_cnt;                      // fast clock divider
    reg [3:0]  rc16;                         // divide by 16 for slow
    reg        dbl_ph;                       // doubled clock phase
    reg        cur_sel;                      // active mux source
    reg        next_sys;                     // next system clock level
    reg        next_div;                     // next divided level
    wire       osc_edge;                     // oscillator rising edge
    wire       slow_edge;                    // slow source edge
    wire       slow_src;                     // slow source level
    wire       hs_en_eff;                    // effective enable
    wire       mode_ext;                     // external mode in force
    wire       want_sel;                     // requested mux source
    wire       hit0;                         // ctrl0 selected
    wire       hit1;                         // ctrl1 selected
    wire       wr;                           // write strobe

    assign hs_en_eff = (REDUCED != 0) ? 1'b1 : ctrl1[`SCSOC_BIT_HSEN];
    assign mode_ext  = (REDUCED == 0) & ctrl0[`SCSOC_BIT_MODE];
    // ext mode counts pin edges, rc mode counts rc edges
    assign osc_edge  = mode_ext ? (ex_sync[1] & ~ex_prev)
                                : (rc_sync[1] & ~rc_prev);
    assign slow_src  = (REDUCED != 0) ? rc16[3] : sl_sync[1];
    assign slow_edge = (REDUCED != 0) ? (rc_sync[1] & ~rc_prev &
                                         (rc16 == 4'hf))
                                      : (sl_sync[1] & ~sl_prev);
    // select forced low while oscillator off, high on reduced part
    assign want_sel  = (REDUCED != 0) ? 1'b1 :
                       (ctrl1[`SCSOC_BIT_SYSSEL] & hs_en_eff);
    assign hit0 = wb_adr_i == `SCSOC_ADDR_CTRL0;
    assign hit1 = wb_adr_i == `SCSOC_ADDR_CTRL1;
    assign wr   = wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i & ~ack;
    assign wb_ack_o = ack;

    // synchronisers; first stage read only by second
    always @(posedge clk_i) begin
        if (rst_i) begin
            rc_sync <= 2'h0;
            sl_sync <= 2'h0;
            ex_sync <= 2'h0;
            wk_sync <= 2'h0;
            st_sync <= 2'h0;
            rc_prev <= 1'b0;
            sl_prev <= 1'b0;
            ex_prev <= 1'b0;
        end else begin
            rc_sync <= {rc_sync[0], rc_osc_i & ~stopped};
            sl_sync <= {sl_sync[0], slow_osc_i & ~stopped};
            ex_sync <= {ex_sync[0], ext_clock_input_pin_i};
            wk_sync <= {wk_sync[0], wake_i};
            st_sync <= {st_sync[0], stop_i};
            rc_prev <= rc_sync[1];
            sl_prev <= sl_sync[1];
            ex_prev <= ex_sync[1];
        end
    end

    // wishbone slave: registered ack one cycle after request, unmapped reads zero
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack   <= 1'b0;
            ctrl0 <= `SCSOC_CTRL0_RESET;
            ctrl1 <= `SCSOC_CTRL1_RESET;
        end else begin
            ack <= wb_cyc_i & wb_stb_i & ~ack;
            if (wr & hit0) begin
                // mode bit only takes while oscillator disabled
                ctrl0[7:3] <= wb_dat_i[7:3];
                ctrl0[1:0] <= wb_dat_i[1:0];
                if (!hs_en_eff)
                    ctrl0[2] <= wb_dat_i[2];
            end
            if (wr & hit1)
                ctrl1[6:0] <= wb_dat_i[6:0];
            else if (!ctrl1[`SCSOC_BIT_HSEN])
                ctrl1[`SCSOC_BIT_SYSSEL] <= 1'b0;
        end
    end

    // read mux with variant fixed bits
    always @* begin
        wb_dat_o = 8'h00;
        if (hit0)
            wb_dat_o = {ctrl0[7:3], mode_ext, ctrl0[1:0]};
        else if (hit1)
            wb_dat_o = {1'b0, ctrl1[6:2], hs_en_eff, want_sel};
    end

    // fast oscillator start and stabilization sequence
    always @(posedge clk_i) begin
        if (rst_i) begin
            stopped    <= 1'b0;
            boot       <= 1'b1;
            hs_start   <= 16'h0000;
            hs_stab    <= 14'h0000;
            hs_ready   <= 1'b0;
            hs_en_prev <= 1'b1;
        end else begin
            hs_en_prev <= hs_en_eff;
            if (st_sync[1] & ~stopped) begin
                stopped  <= 1'b1;
                hs_ready <= 1'b0;
            end else if (stopped & wk_sync[1]) begin
                stopped  <= 1'b0;
                hs_start <= 16'h0000;
                hs_stab  <= 14'h0000;
            end else if (!hs_en_eff) begin
                hs_ready <= 1'b0;
                hs_start <= 16'h0000;
                hs_stab  <= 14'h0000;
            end else if (hs_en_eff & ~hs_en_prev) begin
                hs_start <= 16'h0000;
                hs_stab  <= 14'h0000;
            end else if (!hs_ready & !stopped & osc_edge) begin
                if (hs_start != RC_START)
                    hs_start <= hs_start + 16'h0001;
                else if (hs_stab != (boot ? STAB_LONG
                                          : `SCSOC_STAB_WAKE) - 14'h0001)
                    hs_stab <= hs_stab + 14'h0001;
                else begin
                    hs_ready <= 1'b1;
                    boot     <= 1'b0;
                end
            end
        end
    end

    // slow clock start and stabilization sequence
    always @(posedge clk_i) begin
        if (rst_i) begin
            ls_start <= 16'h0000;
            ls_stab  <= 14'h0000;
            ls_ready <= 1'b0;
        end else if (REDUCED != 0) begin
            ls_ready <= hs_ready;
        end else if (stopped) begin
            ls_start <= 16'h0000;
            ls_stab  <= 14'h0000;
            ls_ready <= 1'b0;
        end else if (!ls_ready & slow_edge) begin
            if (ls_start != XTL_START)
                ls_start <= ls_start + 16'h0001;
            else if (ls_stab != STAB_LONG - 14'h0001)
                ls_stab <= ls_stab + 14'h0001;
            else
                ls_ready <= 1'b1;
        end
    end

    // divided fast clock, doubled and divide-by-16 generators
    always @* begin
        case (ctrl0[1:0])
            2'h0:    next_div = mode_ext ? ex_sync[1] : rc_sync[1];
            2'h1:    next_div = div_cnt[0];
            2'h2:    next_div = div_cnt[1];
            default: next_div = div_cnt[2];
        endcase
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            div_cnt      <= 3'h0;
            rc16         <= 4'h0;
            dbl_ph       <= 1'b0;
            fast_clock_o <= 1'b0;
            fast_oscillator_clock_o <= 1'b0;
            slow_clock_o <= 1'b0;
            doubled_slow_clock_o <= 1'b0;
        end else begin
            if (osc_edge)
                div_cnt <= div_cnt + 3'h1;
            if (rc_sync[1] & ~rc_prev)
                rc16 <= rc16 + 4'h1;
            fast_oscillator_clock_o <= hs_ready &
                (mode_ext ? ex_sync[1] : rc_sync[1]);
            fast_clock_o <= hs_ready & next_div;
            slow_clock_o <= ls_ready & slow_src;
            // doubled clock pulses on both slow edges when enabled
            if (slow_src != dbl_ph)
                dbl_ph <= slow_src;
            doubled_slow_clock_o <= ctrl1[`SCSOC_BIT_DBLEN] & ls_ready &
                                    (slow_src != dbl_ph);
        end
    end

    // glitch-free mux: swap source only while both sides low
    always @* begin
        next_sys = cur_sel ? fast_clock_o : slow_clock_o;
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            cur_sel        <= 1'b1;
            system_clock_o <= 1'b0;
            cpu_stall_o    <= 1'b1;
        end else begin
            if (want_sel != cur_sel && !fast_clock_o && !slow_clock_o)
                cur_sel <= want_sel;
            system_clock_o <= next_sys;
            // stall while chosen source is not yet supplied
            cpu_stall_o <= cur_sel ? ~hs_ready : ~ls_ready;
        end
    end

    // pin control for crystal and external clock pin
    always @(posedge clk_i) begin
        if (rst_i) begin
            ext_pin_gpio_o       <= 1'b1;
            gpio_in_o            <= 1'b0;
            crystal_pin_in_oe_o  <= 1'b0;
            crystal_pin_out_o    <= 1'b0;
            crystal_pin_out_oe_o <= 1'b0;
        end else begin
            ext_pin_gpio_o <= ~mode_ext;
            gpio_in_o      <= ex_sync[1];
            crystal_pin_in_oe_o  <= 1'b0;
            crystal_pin_out_o    <= ~sl_sync[1];
            crystal_pin_out_oe_o <= (REDUCED == 0) & ~stopped;
        end
    end
endmodule

// >>> rtl/scsoc_defines.vh
// register offsets, field positions, reset values and timing counts
`ifndef SCSOC_DEFINES_VH
`define SCSOC_DEFINES_VH
`define SCSOC_ADDR_CTRL0     16'hf002
`define SCSOC_ADDR_CTRL1     16'hf003
`define SCSOC_CTRL0_RESET    8'h33
`define SCSOC_CTRL1_RESET    8'h03
`define SCSOC_BIT_SYSSEL     0
`define SCSOC_BIT_HSEN       1
`define SCSOC_BIT_DBLEN      2
`define SCSOC_BIT_MODE       2
`define SCSOC_STAB_RESET     14'h2000
`define SCSOC_STAB_WAKE      14'h0080
`define SCSOC_RC_START_CYC   16'h0004
`define SCSOC_XTL_START_CYC  16'h0010
`endif

// >>> verification/scsoc_clock_control_asserts.sv
// port checker for the clock control block
module scsoc_clock_control_asserts #(
    parameter int RC_HALF = 20             // rc half period in clk cycles
) (
    input wire        clk_i,
    input wire        rst_i,
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire        wb_we_i,
    input wire [15:0] wb_adr_i,
    input wire [7:0]  wb_dat_i,
    input wire [7:0]  wb_dat_o,
    input wire        wb_ack_o,
    input wire        stop_i,
    input wire        fast_clock_o,
    input wire        system_clock_o,
    input wire        cpu_stall_o,
    input wire        crystal_pin_out_oe_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire acc = wb_cyc_i && wb_stb_i && wb_ack_o;    // access completes
    wire rd  = acc && !wb_we_i;                     // read completes
    wire wr  = acc && wb_we_i;                      // write completes
    wire wr0 = wr && wb_adr_i == 16'hf002;          // divider write
    logic [1:0] div_q;                              // shadow divider field
    logic [1:0] falls;                              // falls since upset
    int         hi_n;                               // fast clock high run
    // shadow the divider and time each fast clock high phase
    always @(posedge clk_i) begin
        if (rst_i) begin
            div_q <= 2'h3;
            falls <= 2'h0;
        end else if (wr || stop_i) begin
            div_q <= wr0 ? wb_dat_i[1:0] : div_q;
            falls <= 2'h0;
        end else if ($fell(fast_clock_o) && falls != 2'h3) begin
            falls <= falls + 2'h1;
        end
        hi_n <= fast_clock_o ? hi_n + 1 : 0;
    end
    property p_ack_latency; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack_latency: assert property (p_ack_latency)
        else $error("ack late");
    property p_unmapped; rd && wb_adr_i != 16'hf002 && wb_adr_i != 16'hf003
        |-> wb_dat_o == 8'h00; endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    property p_bit7; rd && wb_adr_i == 16'hf003 |-> !wb_dat_o[7]; endproperty
    a_bit7: assert property (p_bit7)
        else $error("bit 7 not zero");
    property p_sel_forced; rd && wb_adr_i == 16'hf003 && !wb_dat_o[1]
        |-> !wb_dat_o[0]; endproperty
    a_sel_forced: assert property (p_sel_forced)
        else $error("select set while oscillator off");
    property p_stop_hiz; stop_i [*5] |-> !crystal_pin_out_oe_o; endproperty
    a_stop_hiz: assert property (p_stop_hiz)
        else $error("crystal pin driven in stop");
    property p_sys_high; $rose(system_clock_o) |=> system_clock_o [*8];
    endproperty
    a_sys_high: assert property (p_sys_high)
        else $error("short system clock pulse");
    property p_div; $fell(fast_clock_o) && falls >= 2'h2
        |-> hi_n == (RC_HALF << div_q); endproperty
    a_div: assert property (p_div)
        else $error("fast clock high time wrong");
    property p_stall_reset; $fell(rst_i) |-> cpu_stall_o; endproperty
    a_stall_reset: assert property (p_stall_reset)
        else $error("cpu not held after reset");
    c_div_write: cover property (wr0);
    c_stop: cover property (stop_i [*5]);
    c_sys_rise: cover property ($rose(system_clock_o));
endmodule

// >>> verification/scsoc_osc_model.sv
// oscillator sources seen by the clock control block
module scsoc_osc_model #(
    parameter int RC_HALF   = 20,   // rc half period, 500 khz
    parameter int SLOW_HALF = 64,   // crystal half period, scaled down
    parameter int EXT_HALF  = 40    // external half period, 250 khz
) (
    input  wire logic clk_i,        // bench clock
    input  wire logic stop_i,       // stop mode level
    output logic      rc_osc_o,     // rc oscillator
    output logic      slow_osc_o,   // crystal oscillator
    output logic      ext_clock_o   // external clock source
);
    int   rc_n = 0;                 // rc phase counter
    int   sl_n = 0;                 // crystal phase counter
    int   ex_n = 0;                 // external phase counter
    logic rc_q = 1'b0;              // rc level
    logic sl_q = 1'b0;              // crystal level
    logic ex_q = 1'b0;              // external level
    assign rc_osc_o    = rc_q;
    assign slow_osc_o  = sl_q;
    assign ext_clock_o = ex_q;
    // rc oscillator halts in stop and restarts from low
    always @(posedge clk_i) begin
        rc_n <= (stop_i || rc_n == RC_HALF - 1) ? 0 : rc_n + 1;
        rc_q <= stop_i ? 1'b0 : rc_q ^ (rc_n == RC_HALF - 1);
    end
    // crystal oscillation stops in stop mode
    always @(posedge clk_i) begin
        sl_n <= (stop_i || sl_n == SLOW_HALF - 1) ? 0 : sl_n + 1;
        sl_q <= stop_i ? 1'b0 : sl_q ^ (sl_n == SLOW_HALF - 1);
    end
    // external source runs free, never above 500 khz
    always @(posedge clk_i) begin
        ex_n <= (ex_n == EXT_HALF - 1) ? 0 : ex_n + 1;
        ex_q <= ex_q ^ (ex_n == EXT_HALF - 1);
    end
endmodule

// >>> verification/test_scsoc_clock_control.sv
// testbench for system clock select and oscillator control
module test_scsoc_clock_control;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_i = 1'b0;   // 20 mhz clock
    logic        rst_i = 1'b1;   // reset, high
    logic        cyc = 1'b0;     // cycle, strobe and select
    logic        we = 1'b0;      // write enable
    logic [15:0] adr = 16'h0;    // byte address
    logic [7:0]  wdat = 8'h0;    // write data
    logic        stop = 1'b0;    // stop request
    logic        wake = 1'b0;    // wake pulse
    logic [7:0]  rdat;           // read data
    logic        ack, rc, slw, ext, fosc, sclk, dclk, stall, gpio, xoe;
    logic [7:0]  v;              // last read value
    int          n;              // cycle counter
    int          dcnt = 0;       // cycles doubled clock was high
    int          errors = 0;
    int          compares = 0;
    always #25 clk_i = ~clk_i;
    // accumulate doubled slow clock activity
    always @(posedge clk_i) dcnt <= dcnt + int'(dclk === 1'b1);
    scsoc_osc_model OSC (.clk_i(clk_i), .stop_i(stop), .rc_osc_o(rc),
        .slow_osc_o(slw), .ext_clock_o(ext));
    scsoc_clock_control #(.STAB_LONG(14'h0010)) DUT (.clk_i(clk_i),
        .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(cyc), .wb_dat_o(rdat),
        .wb_ack_o(ack), .rc_osc_i(rc), .slow_osc_i(slw),
        .ext_clock_input_pin_i(ext), .stop_i(stop), .wake_i(wake),
        .fast_clock_o(), .fast_oscillator_clock_o(fosc),
        .slow_clock_o(sclk), .doubled_slow_clock_o(dclk),
        .system_clock_o(), .cpu_stall_o(stall), .ext_pin_gpio_o(gpio),
        .gpio_in_o(), .crystal_pin_in_oe_o(), .crystal_pin_out_o(),
        .crystal_pin_out_oe_o(xoe));
    // one classic wishbone cycle, held until ack is sampled
    task automatic bus(input logic w, input logic [15:0] a,
                       input logic [7:0] d);
        int k;
        @(posedge clk_i);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (ack !== 1'b1 && k < 20);
        v = rdat;
        cyc <= 1'b0;
        if (k >= 20) errors++;
    endtask
    // compare one byte
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // read a register and compare
    task automatic rdchk(input logic [15:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk8(v, e);
    endtask
    // count cycles until the gated oscillator clock rises
    task automatic wait_fosc;
        while (fosc !== 1'b1 && n < 9000) begin
            @(posedge clk_i);
            n++;
        end
    endtask
    // print verdict and end the run
    task automatic test_done;
        if (errors == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // watchdog against a hang
    initial begin
        repeat (60000) @(posedge clk_i);
        errors++;
        test_done();
    end
    // main sequence
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        n = 0;
        wait_fosc();
        chk8({7'h0, n >= 640}, 8'h01);
        rdchk(16'hf003, 8'h03);
        rdchk(16'hf002, 8'h33);
        rdchk(16'hf004, 8'h00);
        n = dcnt;
        for (int d = 0; d < 4; d++) begin
            bus(1'b1, 16'hf002, {6'h0c, d[1:0]});
            repeat (2000) @(posedge clk_i);
            rdchk(16'hf002, {6'h0c, d[1:0]});
        end
        chk8({7'h0, dcnt == n}, 8'h01);
        bus(1'b1, 16'hf002, 8'h37);
        rdchk(16'hf002, 8'h33);
        // slow clock must be running before the switch to it
        while (sclk !== 1'b1 && n < 60000) begin
            @(posedge clk_i);
            n++;
        end
        chk8({7'h0, sclk === 1'b1}, 8'h01);
        bus(1'b1, 16'hf003, 8'h01);
        rdchk(16'hf003, 8'h00);
        bus(1'b1, 16'hf002, 8'h37);
        rdchk(16'hf002, 8'h37);
        chk8({7'h0, gpio}, 8'h00);
        bus(1'b1, 16'hf002, 8'h33);
        // pin flag is registered after the write lands
        repeat (2) @(posedge clk_i);
        chk8({7'h0, gpio}, 8'h01);
        bus(1'b1, 16'hf003, 8'h07);
        n = 0;
        wait_fosc();
        chk8({7'h0, n >= 5120}, 8'h01);
        n = dcnt;
        repeat (512) @(posedge clk_i);
        chk8({7'h0, dcnt != n}, 8'h01);
        stop <= 1'b1;
        repeat (8) @(posedge clk_i);
        chk8({7'h0, xoe}, 8'h00);
        stop <= 1'b0;
        wake <= 1'b1;
        repeat (2) @(posedge clk_i);
        wake <= 1'b0;
        n = 2;
        while (sclk !== 1'b1 && n < 9000) begin
            @(posedge clk_i);
            n++;
        end
        chk8({7'h0, n >= 2048}, 8'h01);
        wait_fosc();
        chk8({7'h0, n >= 5120}, 8'h01);
        repeat (20) @(posedge clk_i);
        chk8({7'h0, stall}, 8'h00);
        test_done();
    end
endmodule
bind scsoc_clock_control scsoc_clock_control_asserts #(.RC_HALF(20)) CHK (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .stop_i(stop_i), .fast_clock_o(fast_clock_o),
    .system_clock_o(system_clock_o), .cpu_stall_o(cpu_stall_o),
    .crystal_pin_out_oe_o(crystal_pin_out_oe_o));
